// ===== design/pld_io_macrocell.v
// Pair of programmable-logic I/O macrocells with shared input multiplexer
//
// What this block does
// - Output register clocks only from its product-term clock; no dedicated clock pin.
// - Every macrocell register starts in its reset state after power-up.
// - Fixed inverter between output register and pin; reset state drives pin high.
// - Reset and preset terms both asserted make the register transparent.
// - Stored value after leaving transparent mode is undefined; do not rely on it.
// - Disabled output buffer still feeds the output register back to the array.
// - Feedback select bit at zero routes the output register value to the array.
// - Feedback select bit at one routes the input register path to the array.
// - Transparent output with select zero feeds back from before the output buffer.
// - Input register is transparent by default or registered with own terms.
// - A macrocell pair offers three array paths: two feedbacks, one shared input.
// - Only one pin of a pair can serve as input while its register is buried.
// - Shared mux passes one input register; even pin default, odd selectable.
//
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "io_macrocell_regs.vh"

module pld_io_macrocell (
    input wire MCLK_IN,
    input wire RST_B_IN,
    // Avalon-MM slave
    input wire [3:0] AVS_ADDRESS_IN,
    input wire AVS_READ_IN,
    input wire AVS_WRITE_IN,
    input wire [31:0] AVS_WRITEDATA_IN,
    input wire [3:0] AVS_BYTEENABLE_IN,
    output reg [31:0] AVS_READDATA_OUT,
    output wire AVS_WAITREQUEST_OUT,
    // Product terms from the array, one bit per macrocell
    input wire [1:0] DATA_TERM_IN,
    input wire [1:0] CLOCK_TERM_IN,
    input wire [1:0] REGISTER_RESET_TERM_IN,
    input wire [1:0] REGISTER_PRESET_TERM_IN,
    input wire [1:0] OE_TERM_IN,
    input wire [1:0] IN_CLOCK_TERM_IN,
    input wire [1:0] IN_SET_TERM_IN,
    input wire [1:0] IN_RESET_TERM_IN,
    // Device pins, split into level, drive value and drive enable
    input wire [1:0] PIN_IN,
    output reg [1:0] PIN_OUT,
    output reg [1:0] PIN_OE_OUT,
    // Paths into the product-term array
    output reg [1:0] FEEDBACK_OUT,
    output reg SHARED_INPUT_OUT
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    reg [`MC_SYNC_WIDTH-1:0] sync1_q;
    reg [`MC_SYNC_WIDTH-1:0] sync2_q;
    reg [1:0] clk_prev_q;
    reg [1:0] in_clk_prev_q;
    reg [`MC_CFG_WIDTH-1:0] config_q;
    reg ack_q;
    wire [`MC_SYNC_WIDTH-1:0] raw_terms;
    wire [1:0] d_s;
    wire [1:0] clk_s;
    wire [1:0] rst_s;
    wire [1:0] pre_s;
    wire [1:0] oe_s;
    wire [1:0] iclk_s;
    wire [1:0] iset_s;
    wire [1:0] irst_s;
    wire [1:0] pin_s;
    wire [1:0] out_tick;
    wire [1:0] in_tick;
    wire [1:0] out_value;
    wire [1:0] out_state;
    wire [1:0] in_value;
    wire [1:0] in_state;
    wire [1:0] out_transparent;
    wire [1:0] feedback_select_bit;
    wire [1:0] in_registered;
    wire shared_odd;
    wire [1:0] feedback_d;
    wire shared_d;
    wire bus_req;
    wire bus_done;
    wire [`MC_STS_WIDTH-1:0] status_word;
    wire cfg_write;
    reg [31:0] rdata_d;

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    // Terms and pins come from outside this clock and pass two flops
    assign raw_terms = {
        PIN_IN,
        IN_RESET_TERM_IN,
        IN_SET_TERM_IN,
        IN_CLOCK_TERM_IN,
        OE_TERM_IN,
        REGISTER_PRESET_TERM_IN,
        REGISTER_RESET_TERM_IN,
        CLOCK_TERM_IN,
        DATA_TERM_IN
    };

    // First stage; may go metastable, so no logic reads it
    always @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            sync1_q <= {`MC_SYNC_WIDTH{1'b0}};
        end else begin
            sync1_q <= raw_terms;
        end
    end

    // Second stage; the only copy that the cell logic reads
    always @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            sync2_q <= {`MC_SYNC_WIDTH{1'b0}};
        end else begin
            sync2_q <= sync1_q;
        end
    end

    // Synchronised term fields
    assign d_s = sync2_q[1:0];
    assign clk_s = sync2_q[3:2];
    assign rst_s = sync2_q[5:4];
    assign pre_s = sync2_q[7:6];
    assign oe_s = sync2_q[9:8];
    assign iclk_s = sync2_q[11:10];
    assign iset_s = sync2_q[13:12];
    assign irst_s = sync2_q[15:14];
    assign pin_s = sync2_q[17:16];

    // ------------------------------------------------------------------------
    // Product-term clock edges
    // ------------------------------------------------------------------------
    // Previous output clock term level; idle low, so no false edge after reset
    always @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            clk_prev_q <= 2'h0;
        end else begin
            clk_prev_q <= clk_s;
        end
    end

    // Previous input clock term level for rising-edge detection
    always @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            in_clk_prev_q <= 2'h0;
        end else begin
            in_clk_prev_q <= iclk_s;
        end
    end

    // One-cycle enables on each rising term clock edge
    assign out_tick = clk_s & ~clk_prev_q;
    assign in_tick = iclk_s & ~in_clk_prev_q;

    // ------------------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------------------
    assign out_transparent = config_q[`MC_CFG_OUT_TRANSPARENT_LSB +: 2];
    assign feedback_select_bit = config_q[`MC_CFG_FEEDBACK_SELECT_BIT_LSB +: 2];
    assign in_registered = config_q[`MC_CFG_IN_REGISTERED_LSB +: 2];
    assign shared_odd = config_q[`MC_CFG_SHARED_ODD_BIT];

    // ------------------------------------------------------------------------
    // Macrocell storage: output and input register of each cell
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `MC_CELLS; gi = gi + 1) begin : g_cell
            // Output register with term clock, set, reset and transparent mode
            mc_store_cell u_out (
                .clk_in(MCLK_IN),
                .rst_b_in(RST_B_IN),
                .tick_in(out_tick[gi]),
                .d_in(d_s[gi]),
                .set_in(pre_s[gi]),
                .clr_in(rst_s[gi]),
                .transparent_in(out_transparent[gi]),
                .value_out(out_value[gi]),
                .state_out(out_state[gi])
            );

            // Input register fed from the pin, transparent unless configured
            mc_store_cell u_in (
                .clk_in(MCLK_IN),
                .rst_b_in(RST_B_IN),
                .tick_in(in_tick[gi]),
                .d_in(pin_s[gi]),
                .set_in(iset_s[gi]),
                .clr_in(irst_s[gi]),
                .transparent_in(~in_registered[gi]),
                .value_out(in_value[gi]),
                .state_out(in_state[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Feedback and shared input multiplexers
    // ------------------------------------------------------------------------
    // Feedback is taken before the output buffer, independent of its enable
    assign feedback_d[0] = feedback_select_bit[0] ? in_value[0] : out_value[0];
    assign feedback_d[1] = feedback_select_bit[1] ? in_value[1] : out_value[1];

    // Only one pin of the pair reaches the shared array input, even pin by default
    assign shared_d = shared_odd ? in_value[1] : in_value[0];

    // Registered feedback of each cell, two of the three array paths
    always @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            FEEDBACK_OUT <= 2'h0;
        end else begin
            FEEDBACK_OUT <= feedback_d;
        end
    end

    // Registered shared pin input, the third path of the pair
    always @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            SHARED_INPUT_OUT <= 1'b0;
        end else begin
            SHARED_INPUT_OUT <= shared_d;
        end
    end

    // ------------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------------
    // Inverted register value; reset state shows as a high pin
    always @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            PIN_OUT <= `MC_PIN_OUT_RESET;
        end else begin
            PIN_OUT <= ~out_value;
        end
    end

    // Drive enable follows the synchronised enable term
    always @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            PIN_OE_OUT <= `MC_PIN_OE_RESET;
        end else begin
            PIN_OE_OUT <= oe_s;
        end
    end

    // ------------------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------------------
    // Every access waits exactly one cycle, then completes
    assign bus_req = AVS_READ_IN | AVS_WRITE_IN;
    assign bus_done = bus_req & ack_q;
    assign AVS_WAITREQUEST_OUT = bus_req & ~ack_q;

    // Accepted configuration write; status and unmapped writes are dropped
    assign cfg_write = bus_done & AVS_WRITE_IN & (AVS_ADDRESS_IN == `MC_CONFIG_OFFSET) &
                       AVS_BYTEENABLE_IN[0];

    // Status snapshot of the pair
    assign status_word = {PIN_OE_OUT, shared_d, feedback_d, in_state, out_state};

    // Handshake acknowledge
    always @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req & ~ack_q;
        end
    end

    // Configuration write, taken on the edge after the wait, while waitrequest is low
    always @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            config_q <= `MC_CONFIG_RESET;
        end else if (cfg_write) begin
            config_q <= AVS_WRITEDATA_IN[`MC_CFG_WIDTH-1:0];
        end
    end

    // Read word by address; unmapped words read zero
    always @* begin
        rdata_d = 32'h0000_0000;
        case (AVS_ADDRESS_IN)
            `MC_CONFIG_OFFSET: begin
                rdata_d = {{(32-`MC_CFG_WIDTH){1'b0}}, config_q};
            end
            `MC_STATUS_OFFSET: begin
                rdata_d = {{(32-`MC_STS_WIDTH){1'b0}}, status_word};
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    // Read data, registered during the wait cycle
    always @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            AVS_READDATA_OUT <= 32'h0000_0000;
        end else if (AVS_READ_IN && !ack_q) begin
            AVS_READDATA_OUT <= rdata_d;
        end
    end

endmodule

`default_nettype wire

// ===== design/io_macrocell_regs.vh
// Register offsets, field positions and reset values of the I/O macrocell pair
`ifndef IO_MACROCELL_REGS_VH
`define IO_MACROCELL_REGS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define MC_CONFIG_OFFSET 4'h0
`define MC_STATUS_OFFSET 4'h4

// ----------------------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------------------
`define MC_CFG_OUT_TRANSPARENT_LSB 0
`define MC_CFG_FEEDBACK_SELECT_BIT_LSB 2
`define MC_CFG_IN_REGISTERED_LSB 4
`define MC_CFG_SHARED_ODD_BIT 6
`define MC_CFG_WIDTH 7
`define MC_CONFIG_RESET 7'h00
`define MC_PIN_OUT_RESET 2'h3
`define MC_PIN_OE_RESET 2'h0

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define MC_STS_OUT_STATE_LSB 0
`define MC_STS_IN_STATE_LSB 2
`define MC_STS_FEEDBACK_LSB 4
`define MC_STS_SHARED_BIT 6
`define MC_STS_PIN_OE_LSB 7
`define MC_STS_WIDTH 9

// ----------------------------------------------------------------------------
// Pin and synchroniser sizes
// ----------------------------------------------------------------------------
`define MC_CELLS 2
`define MC_SYNC_WIDTH 18

`endif

// ===== design/mc_store_cell.v
// Macrocell storage element with term clock, set, reset and transparent mode
`timescale 1ns/1ps
`default_nettype none

module mc_store_cell (
    input wire clk_in,
    input wire rst_b_in,
    input wire tick_in,
    input wire d_in,
    input wire set_in,
    input wire clr_in,
    input wire transparent_in,
    output wire value_out,
    output wire state_out
);

    reg state_q;
    wire pass_through;

    // ------------------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------------------
    // Set and reset together, or a transparent configuration, bypass storage
    assign pass_through = transparent_in | (set_in & clr_in);
    assign value_out = pass_through ? d_in : state_q;
    assign state_out = state_q;

    // ------------------------------------------------------------------------
    // Stored bit
    // ------------------------------------------------------------------------
    // Reset state is zero; set and reset act without a term clock edge
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= 1'b0;
        end else if (set_in & clr_in) begin
            state_q <= state_q; // value after leaving pass-through is unspecified
        end else if (set_in) begin
            state_q <= 1'b1;
        end else if (clr_in) begin
            state_q <= 1'b0;
        end else if (tick_in) begin
            state_q <= d_in;
        end
    end

endmodule

`default_nettype wire

// ===== tb/pin_side_model.sv
// Far side of the two pins: cell drive, an outside driver or a floating pattern
`timescale 1ns/1ps
`default_nettype none
module pin_side_model (
    input wire clk_in,
    input wire [1:0] drv_in,
    input wire [1:0] drv_en_in,
    input wire [1:0] ext_in,
    input wire [1:0] ext_en_in,
    output logic [1:0] level_out
);
    logic [1:0] float_q = 2'h1;
    // An undriven pin changes every cycle, so no stale level is read
    always @(posedge clk_in) begin
        float_q <= ~float_q;
    end
    // Enabled cell drive wins, a disabled one leaves the pin to others
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            level_out[i] = drv_en_in[i] ? drv_in[i] : (ext_en_in[i] ? ext_in[i] : float_q[i]);
        end
    end
endmodule
`default_nettype wire

// ===== tb/pld_io_macrocell_props.sv
// Port checks for the I/O macrocell pair
`timescale 1ns/1ps
`default_nettype none
module mc_props (
    input wire MCLK_IN,
    input wire RST_B_IN,
    input wire [3:0] AVS_ADDRESS_IN,
    input wire AVS_READ_IN,
    input wire AVS_WRITE_IN,
    input wire [31:0] AVS_WRITEDATA_IN,
    input wire [3:0] AVS_BYTEENABLE_IN,
    input wire AVS_WAITREQUEST_OUT,
    input wire [1:0] DATA_TERM_IN,
    input wire [1:0] REGISTER_RESET_TERM_IN,
    input wire [1:0] REGISTER_PRESET_TERM_IN,
    input wire [1:0] OE_TERM_IN,
    input wire [1:0] PIN_IN,
    input wire [1:0] PIN_OUT,
    input wire [1:0] PIN_OE_OUT,
    input wire [1:0] FEEDBACK_OUT,
    input wire SHARED_INPUT_OUT
);
    logic [6:0] cfg_q;
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RST_B_IN);
    // Shadow of the configuration word, taken from accepted writes
    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            cfg_q <= 7'h00;
        end else if (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == 4'h0
            && AVS_BYTEENABLE_IN[0]) begin
            cfg_q <= AVS_WRITEDATA_IN[6:0];
        end
    end
    // ----------
    // Properties
    // ----------
    property p_rst; $rose(RST_B_IN) |-> PIN_OUT == 2'h3 && PIN_OE_OUT == 2'h0; endproperty
    a_rst: assert property (p_rst) else $error("pins not in reset state");
    property p_oe; ($stable(OE_TERM_IN))[*6] |-> PIN_OE_OUT == OE_TERM_IN; endproperty
    a_oe: assert property (p_oe) else $error("drive enable wrong");
    property p_sr; (!cfg_q[0] && $stable(REGISTER_RESET_TERM_IN[0])
        && REGISTER_RESET_TERM_IN[0] != REGISTER_PRESET_TERM_IN[0])[*6]
        |-> PIN_OUT[0] == REGISTER_RESET_TERM_IN[0]; endproperty
    a_sr: assert property (p_sr) else $error("set or reset level wrong at pin");
    property p_trn; ($stable(DATA_TERM_IN[0]) && REGISTER_RESET_TERM_IN[0]
        && REGISTER_PRESET_TERM_IN[0])[*6] |-> PIN_OUT[0] == !DATA_TERM_IN[0]; endproperty
    a_trn: assert property (p_trn) else $error("not transparent");
    property p_fb; (!cfg_q[2])[*3] |-> FEEDBACK_OUT[0] == !PIN_OUT[0]; endproperty
    a_fb: assert property (p_fb) else $error("feedback not the stored value");
    property p_even; (!cfg_q[4] && !cfg_q[6] && $stable(PIN_IN[0]))[*6]
        |-> SHARED_INPUT_OUT == PIN_IN[0]; endproperty
    a_even: assert property (p_even) else $error("even pin not passed");
    property p_odd; (cfg_q[6] && !cfg_q[5] && $stable(PIN_IN[1]))[*6]
        |-> SHARED_INPUT_OUT == PIN_IN[1]; endproperty
    a_odd: assert property (p_odd) else $error("odd pin not passed");
    property p_wait; ($rose(AVS_READ_IN) || $rose(AVS_WRITE_IN))
        |-> AVS_WAITREQUEST_OUT ##1 !AVS_WAITREQUEST_OUT; endproperty
    a_wait: assert property (p_wait) else $error("waitrequest timing wrong");
    c_trn: cover property (REGISTER_RESET_TERM_IN[0] && REGISTER_PRESET_TERM_IN[0]);
    c_odd: cover property (cfg_q[6] && SHARED_INPUT_OUT);
    c_wr: cover property (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT);
endmodule
bind pld_io_macrocell mc_props chk (.MCLK_IN(MCLK_IN), .RST_B_IN(RST_B_IN),
    .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
    .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN), .AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN),
    .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .DATA_TERM_IN(DATA_TERM_IN),
    .REGISTER_RESET_TERM_IN(REGISTER_RESET_TERM_IN), .OE_TERM_IN(OE_TERM_IN),
    .REGISTER_PRESET_TERM_IN(REGISTER_PRESET_TERM_IN), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
    .PIN_OE_OUT(PIN_OE_OUT), .FEEDBACK_OUT(FEEDBACK_OUT), .SHARED_INPUT_OUT(SHARED_INPUT_OUT));
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the I/O macrocell pair
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, rst_b, rd, wr, wreq, shr;
    logic [3:0] adr, be;
    logic [31:0] wd, rdat, got;
    logic [1:0] dt, ct, rt, pt, ot, ict, ist, irt, pin, pdrv, poe, fb, xv, xe;
    int n_fail, n_compared, cyc;
    pld_io_macrocell DUT (.MCLK_IN(clk), .RST_B_IN(rst_b), .AVS_ADDRESS_IN(adr),
        .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(be),
        .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wreq), .DATA_TERM_IN(dt),
        .CLOCK_TERM_IN(ct), .REGISTER_RESET_TERM_IN(rt), .REGISTER_PRESET_TERM_IN(pt),
        .OE_TERM_IN(ot), .IN_CLOCK_TERM_IN(ict), .IN_SET_TERM_IN(ist), .IN_RESET_TERM_IN(irt),
        .PIN_IN(pin), .PIN_OUT(pdrv), .PIN_OE_OUT(poe), .FEEDBACK_OUT(fb),
        .SHARED_INPUT_OUT(shr));
    pin_side_model far (.clk_in(clk), .drv_in(pdrv), .drv_en_in(poe), .ext_in(xv),
        .ext_en_in(xe), .level_out(pin));
    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Comparison, verdict and bus access helpers
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task ck2(input logic [1:0] seen, input logic [1:0] exp);
        check({30'h0, seen}, {30'h0, exp});
    endtask
    task conclude;
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task acc(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
        @(posedge clk) {adr, wd, be} <= {a, d, b};
        {wr, rd} <= {w, !w};
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        got = rdat;
        {wr, rd} <= 2'h0;
    endtask
    task rdc(input logic [3:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0, 4'hf);
        check(got, e);
    endtask
    // Terms pass a two-stage synchroniser before the outputs move
    task settle;
        repeat (8) @(posedge clk);
        #1;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        {rst_b, rd, wr, adr, be, wd} = 43'h0;
        {dt, ct, rt, pt, ot, ict, ist, irt, xv} = 18'h0;
        xe = 2'h3;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        settle();
        ck2(pdrv, 2'h3);
        ck2(poe, 2'h0);
        ck2(fb, 2'h0);
        rdc(4'h0, 32'h0);
        acc(1'b1, 4'h8, 32'h7f, 4'hf);
        rdc(4'h8, 32'h0);
        acc(1'b1, 4'h0, 32'h7f, 4'h0);
        rdc(4'h0, 32'h0);
        @(posedge clk) {dt, ot, xe} <= 6'h3c;
        settle();
        ck2(poe, 2'h3);
        ck2(pdrv, 2'h3);
        @(posedge clk) ct <= 2'h3;
        settle();
        ck2(pdrv, 2'h0);
        ck2(fb, 2'h3);
        // Status ignores writes: enables, shared 0, feedback, input 0, stored bits
        acc(1'b1, 4'h4, 32'h1ff, 4'hf);
        rdc(4'h4, 32'h1b3);
        @(posedge clk) {dt, ot} <= 4'h0;
        settle();
        ck2(poe, 2'h0);
        ck2(fb, 2'h3);
        @(posedge clk) rt <= 2'h1;
        settle();
        ck2(pdrv, 2'h1);
        ck2(fb, 2'h2);
        @(posedge clk) {rt, pt} <= 4'h1;
        settle();
        ck2(pdrv, 2'h0);
        @(posedge clk) rt <= 2'h1;
        settle();
        ck2(pdrv, 2'h1);
        @(posedge clk) dt <= 2'h1;
        settle();
        ck2(pdrv, 2'h0);
        @(posedge clk) {rt, pt} <= 4'h0;
        acc(1'b1, 4'h0, 32'h3, 4'hf);
        @(posedge clk) dt <= 2'h2;
        settle();
        ck2(fb, 2'h2);
        ck2(pdrv, 2'h1);
        acc(1'b1, 4'h0, 32'h7, 4'hf);
        @(posedge clk) {xe, xv} <= 4'h5;
        settle();
        ck2(fb, 2'h3);
        @(posedge clk) xv <= 2'h0;
        settle();
        ck2(fb, 2'h2);
        acc(1'b1, 4'h0, 32'h10, 4'hf);
        @(posedge clk) ist <= 2'h1;
        settle();
        ck2({1'b0, shr}, 2'h1);
        @(posedge clk) {ist, irt} <= 4'h1;
        settle();
        ck2({1'b0, shr}, 2'h0);
        @(posedge clk) {irt, xv} <= 4'h1;
        settle();
        ck2({1'b0, shr}, 2'h0);
        @(posedge clk) ict <= 2'h1;
        settle();
        ck2({1'b0, shr}, 2'h1);
        acc(1'b1, 4'h0, 32'h40, 4'hf);
        rdc(4'h0, 32'h40);
        @(posedge clk) {xe, xv} <= 4'he;
        settle();
        ck2({1'b0, shr}, 2'h1);
        @(posedge clk) xv <= 2'h1;
        settle();
        ck2({1'b0, shr}, 2'h0);
        acc(1'b1, 4'h0, 32'h0, 4'hf);
        settle();
        ck2({1'b0, shr}, 2'h1);
        conclude();
    end
endmodule
`default_nettype wire
